// ==== hdl/sch_pkg.sv ====
// Package of constants and types for the channel hop controller
package sch_pkg;
    // ----------------
    // Register offsets (word index on the plain register port)
    // ----------------
    localparam logic [7:0] REG_INTEGER     = 8'h00;
    localparam logic [7:0] REG_FRAC_HIGH   = 8'h01;
    localparam logic [7:0] REG_FRAC_MID    = 8'h02;
    localparam logic [7:0] REG_FRAC_LOW    = 8'h03;
    localparam logic [7:0] REG_STEP_HIGH   = 8'h04;
    localparam logic [7:0] REG_STEP_LOW    = 8'h05;
    localparam logic [7:0] REG_OUTDIV      = 8'h06;
    localparam logic [7:0] REG_HOP_CTRL    = 8'h07;
    localparam logic [7:0] REG_TABLE_SIZE  = 8'h08;
    localparam logic [7:0] REG_RSSI_THRESH = 8'h09;
    localparam logic [7:0] REG_PRE_TIMEOUT = 8'h0a;
    localparam logic [7:0] REG_SYNC_TMO    = 8'h0b;
    localparam logic [7:0] REG_CAL_COUNT   = 8'h0c;
    localparam logic [7:0] REG_STATUS      = 8'h0d;
    localparam logic [7:0] REG_CHANNEL     = 8'h0e;
    localparam logic [7:0] REG_FREQ_B0     = 8'h10;
    localparam logic [7:0] REG_TABLE_BASE  = 8'h40;
    // ----------------
    // Hop control fields
    // ----------------
    localparam int HC_AUTO_BIT  = 0;
    localparam int HC_RSSI_BIT  = 1;
    localparam int HC_PRE_BIT   = 2;
    localparam int HC_SYNC_BIT  = 3;
    localparam int HC_RAW_BIT   = 4;
    localparam int HC_GPIO_BIT  = 5;
    localparam int HC_EXTB_BIT  = 6;
    // ----------------
    // Reset values and constants
    // ----------------
    localparam logic [7:0] INTEGER_RESET = 8'h3c;
    localparam logic [7:0] OUTDIV_RESET  = 8'h04;
    localparam logic [7:0] CHANNEL_RESET = 8'h00;
    localparam logic [7:0] UNUSED_ENTRY  = 8'hff;
    localparam logic [6:0] TABLE_MAX     = 7'h40;
    localparam int FRAC_BITS = 19;
    localparam int CLK_MHZ   = 200;
    // ----------------
    // Timing: hop turnaround in us and derived cycles
    // ----------------
    localparam int AUTO_HOP_US   = 115;
    localparam int MANUAL_HOP_US = 75;
    localparam int AUTO_HOP_CYC   = AUTO_HOP_US * CLK_MHZ;
    localparam int MANUAL_HOP_CYC = MANUAL_HOP_US * CLK_MHZ;
    localparam int TMO_UNIT_CYC   = 200;
    typedef enum logic [2:0] {
        ST_IDLE, ST_TX, ST_RX_TUNE, ST_RX_LISTEN, ST_RX_STAY, ST_SEEK
    } sch_state_t;
endpackage

// ==== hdl/sch_hop_control.sv ====
// Synthesizer word, channel and receive hop controller
// Summary of operation
// - Word = (integer + frac/2^19) * 2 xtal / outdiv
// - Standard divider accepts 24, 12, 8, 4
// - Extended divider accepts 24, 16, 12, 8, 6, 4
// - Frequency is base plus channel times step
// - Step size split into high, low bytes
// - Start channel argument optional, else kept
// - Stored channel resets to zero
// - Hop table of 64 entries, sized
// - Table visited first to last, wrapping
// - Entries holding 0xff are skipped, unless every entry holds 0xff
// - Auto hopping starts on entering receive
// - RSSI, preamble, sync conditions; stay beats hop each cycle
// - Stay above RSSI threshold, hop at or below
// - Raw mode uses RSSI condition only
// - Automatic hop completes in 115 us, one cycle longer per skipped entry
// - Manual hop command retunes in 75 us
// - Optional output toggles per automatic hop and per wrap that lands on a used entry 0
// - Transmit modulation offsets the fraction
module sch_hop_control #(
    parameter int AUTO_HOP_CYCLES   = sch_pkg::AUTO_HOP_CYC,
    parameter int MANUAL_HOP_CYCLES = sch_pkg::MANUAL_HOP_CYC,
    parameter int TMO_UNIT_CYCLES   = sch_pkg::TMO_UNIT_CYC,
    parameter int XTAL_HZ           = 30000000
) (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        cmd_start_rx_i,
    input  wire logic        cmd_start_tx_i,
    input  wire logic        cmd_has_chan_i,
    input  wire logic [7:0]  cmd_chan_i,
    input  wire logic        cmd_rx_hop_i,
    input  wire logic        cmd_idle_i,
    input  wire logic [7:0]  rssi_i,
    input  wire logic        preamble_ok_i,
    input  wire logic        sync_ok_i,
    input  wire logic [15:0] tx_mod_i,
    output logic      [47:0] synth_word_o,
    output logic      [7:0]  outdiv_o,
    output logic      [15:0] cal_count_o,
    output logic      [7:0]  channel_o,
    output logic             tuning_o,
    output logic             receiving_o,
    output logic             hop_gpio_o,
    output logic             div_error_o
);
    import sch_pkg::*;

    // ----------------
    // Configuration registers
    // ----------------
    logic [7:0]  integer_divide_value;
    logic [23:0] fraction_divide_value;
    logic [15:0] step_size;
    logic [7:0]  outdiv;
    logic [7:0]  hop_ctrl;
    logic [6:0]  table_size;
    logic [7:0]  signal_level_threshold;
    logic [7:0]  preamble_timeout_setting;
    logic [7:0]  sync_timeout_setting;
    logic [15:0] oscillator_cal_count;
    logic [7:0]  hop_table [64];
    logic        cal_wr_hi;

    // Live state
    sch_state_t  state;
    logic [7:0]  channel;
    logic [5:0]  hop_index;
    logic [5:0]  seek_left;
    logic [23:0] tune_cnt;
    logic [23:0] tmo_cnt;
    logic        gpio_q;
    logic [1:0]  pre_sync;
    logic [1:0]  syn_sync;
    logic [15:0] rssi_sync;
    logic        sync_phase;

    // ----------------
    // Input synchronisers
    // ----------------
    always_ff @(posedge clk_sys_i) begin
        pre_sync  <= {pre_sync[0], preamble_ok_i};
        syn_sync  <= {syn_sync[0], sync_ok_i};
        rssi_sync <= {rssi_sync[7:0], rssi_i};
    end
    wire logic       preamble_seen = pre_sync[1];
    wire logic       sync_seen     = syn_sync[1];
    wire logic [7:0] rssi_now      = rssi_sync[15:8];

    // ----------------
    // Address decode
    // ----------------
    wire logic is_table = reg_addr_i[7:6] == REG_TABLE_BASE[7:6];
    wire logic [5:0] tbl_addr = reg_addr_i[5:0];

    // Divider legality per band variant
    wire logic ext_band = hop_ctrl[HC_EXTB_BIT];
    wire logic div_std_ok = (reg_wdata_i == 8'h18) || (reg_wdata_i == 8'h0c)
                         || (reg_wdata_i == 8'h08) || (reg_wdata_i == 8'h04);
    wire logic div_ext_ok = div_std_ok || (reg_wdata_i == 8'h10)
                         || (reg_wdata_i == 8'h06);
    wire logic div_ok = ext_band ? div_ext_ok : div_std_ok;

    // ----------------
    // Frequency: base plus channel times step, modulation on frac
    // ----------------
    wire logic [23:0] chan_offset = 24'(channel * step_size);
    wire logic [27:0] base_word = {1'b0, integer_divide_value, FRAC_BITS'(0)}
                                + 28'(fraction_divide_value);
    wire logic [27:0] tx_offset = (state == ST_TX) ? 28'(signed'(tx_mod_i))
                                                   : 28'h0000000;
    wire logic [27:0] eff_word = base_word + 28'(chan_offset) + tx_offset;
    wire logic [63:0] rf_prod = 64'(eff_word) * 64'(2 * XTAL_HZ);
    wire logic [63:0] rf_hz_q19 = rf_prod / 64'(outdiv);

    // ----------------
    // Hop table walk
    // ----------------
    wire logic [5:0] last_index = 6'(table_size - 7'h01);
    wire logic at_end   = (hop_index == last_index) || (table_size == 7'h00);
    wire logic [5:0] next_index = at_end ? 6'h00 : hop_index + 6'h01;
    wire logic [7:0] cur_entry = hop_table[hop_index];
    wire logic entry_unused = cur_entry == UNUSED_ENTRY;
    wire logic auto_en = hop_ctrl[HC_AUTO_BIT] && (table_size != 7'h00);

    // Hop conditions; raw mode leaves only RSSI
    wire logic raw_mode = hop_ctrl[HC_RAW_BIT];
    wire logic rssi_en  = hop_ctrl[HC_RSSI_BIT];
    wire logic pre_en   = hop_ctrl[HC_PRE_BIT] && !raw_mode;
    wire logic sync_en  = hop_ctrl[HC_SYNC_BIT] && !raw_mode;
    wire logic rssi_hop  = rssi_en && (rssi_now <= signal_level_threshold);
    wire logic rssi_stay = rssi_en && (rssi_now > signal_level_threshold);
    wire logic [23:0] pre_limit =
        24'(preamble_timeout_setting) * 24'(TMO_UNIT_CYCLES);
    wire logic [23:0] sync_limit =
        24'(sync_timeout_setting) * 24'(TMO_UNIT_CYCLES);
    wire logic pre_hop  = pre_en && !sync_phase && !preamble_seen
                       && (tmo_cnt >= pre_limit);
    wire logic sync_hop = sync_en && sync_phase && !sync_seen
                       && (tmo_cnt >= sync_limit);
    wire logic pkt_stay = (pre_en || sync_en) && sync_seen;
    // A met stay condition overrides every hop condition, checked each cycle
    wire logic decide_stay = rssi_stay || pkt_stay;
    wire logic decide_hop  = !decide_stay && (rssi_hop || pre_hop || sync_hop);

    wire logic start_cmd = cmd_start_rx_i || cmd_start_tx_i;
    wire logic [7:0] start_chan = cmd_has_chan_i ? cmd_chan_i : channel;

    // ----------------
    // Register writes
    // ----------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            integer_divide_value     <= INTEGER_RESET;
            fraction_divide_value    <= 24'h080000;
            step_size                <= 16'h0000;
            outdiv                   <= OUTDIV_RESET;
            hop_ctrl                 <= 8'h00;
            table_size               <= 7'h00;
            signal_level_threshold   <= 8'h00;
            preamble_timeout_setting <= 8'h00;
            sync_timeout_setting     <= 8'h00;
            oscillator_cal_count     <= 16'h0000;
            cal_wr_hi                <= 1'b0;
            div_error_o              <= 1'b0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                REG_INTEGER:     integer_divide_value <= reg_wdata_i;
                REG_FRAC_HIGH:   fraction_divide_value[23:16] <= reg_wdata_i;
                REG_FRAC_MID:    fraction_divide_value[15:8]  <= reg_wdata_i;
                REG_FRAC_LOW:    fraction_divide_value[7:0]   <= reg_wdata_i;
                REG_STEP_HIGH:   step_size[15:8] <= reg_wdata_i;
                REG_STEP_LOW:    step_size[7:0]  <= reg_wdata_i;
                REG_OUTDIV: begin
                    if (div_ok) begin
                        outdiv <= reg_wdata_i;
                    end
                    div_error_o <= !div_ok;
                end
                REG_HOP_CTRL:    hop_ctrl <= reg_wdata_i;
                REG_TABLE_SIZE: begin
                    table_size <= (reg_wdata_i > 8'(TABLE_MAX)) ? TABLE_MAX
                                : reg_wdata_i[6:0];
                end
                REG_RSSI_THRESH: signal_level_threshold <= reg_wdata_i;
                REG_PRE_TIMEOUT: preamble_timeout_setting <= reg_wdata_i;
                REG_SYNC_TMO:    sync_timeout_setting <= reg_wdata_i;
                REG_CAL_COUNT: begin
                    // High byte first, then low byte
                    if (cal_wr_hi) begin
                        oscillator_cal_count[7:0] <= reg_wdata_i;
                    end else begin
                        oscillator_cal_count[15:8] <= reg_wdata_i;
                    end
                    cal_wr_hi <= !cal_wr_hi;
                end
                default: ;
            endcase
        end
    end

    // Hop table storage
    always_ff @(posedge clk_sys_i) begin
        if (reg_wr_i && is_table) begin
            hop_table[tbl_addr] <= reg_wdata_i;
        end
    end

    // ----------------
    // Radio state machine
    // ----------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state      <= ST_IDLE;
            channel    <= CHANNEL_RESET;
            hop_index  <= 6'h00;
            seek_left  <= 6'h00;
            tune_cnt   <= 24'h000000;
            tmo_cnt    <= 24'h000000;
            sync_phase <= 1'b0;
            gpio_q     <= 1'b0;
        end else if (cmd_idle_i) begin
            state <= ST_IDLE;
        end else if (start_cmd) begin
            channel   <= start_chan;
            hop_index <= 6'h00;
            tmo_cnt   <= 24'h000000;
            sync_phase <= 1'b0;
            tune_cnt  <= 24'(AUTO_HOP_CYCLES - 1);
            state     <= cmd_start_tx_i ? ST_TX : ST_RX_TUNE;
        end else if (cmd_rx_hop_i && state != ST_IDLE && state != ST_TX) begin
            channel  <= cmd_has_chan_i ? cmd_chan_i : channel;
            tmo_cnt  <= 24'h000000;
            sync_phase <= 1'b0;
            tune_cnt <= 24'(MANUAL_HOP_CYCLES - 1);
            state    <= ST_RX_TUNE;
        end else begin
            case (state)
                ST_IDLE: ;
                ST_TX: ;
                ST_RX_TUNE: begin
                    if (tune_cnt == 24'h000000) begin
                        tmo_cnt <= 24'h000000;
                        sync_phase <= 1'b0;
                        state   <= ST_RX_LISTEN;
                    end else begin
                        tune_cnt <= tune_cnt - 24'h000001;
                    end
                end
                ST_RX_LISTEN, ST_RX_STAY: begin
                    tmo_cnt <= tmo_cnt + 24'h000001;
                    if (preamble_seen && !sync_phase) begin
                        sync_phase <= 1'b1;
                        tmo_cnt    <= 24'h000000;
                    end
                    if (auto_en && decide_stay) begin
                        state <= ST_RX_STAY;
                    end else if (auto_en && decide_hop) begin
                        hop_index <= next_index;
                        seek_left <= 6'(table_size - 7'h01);
                        gpio_q    <= gpio_q ^ hop_ctrl[HC_GPIO_BIT];
                        state     <= ST_SEEK;
                    end
                end
                ST_SEEK: begin
                    // One entry looked at per cycle; each skipped entry adds one cycle past the budget
                    if (!entry_unused || seek_left == 6'h00) begin
                        channel  <= hop_table[hop_index];
                        tune_cnt <= 24'(AUTO_HOP_CYCLES - 2);
                        state    <= ST_RX_TUNE;
                    end else begin
                        hop_index <= next_index;
                        seek_left <= seek_left - 6'h01;
                    end
                    if (hop_index == 6'h00 && !entry_unused) begin
                        gpio_q <= gpio_q ^ hop_ctrl[HC_GPIO_BIT];
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------
    // Read path and outputs
    // ----------------
    wire logic [7:0] status = {5'h00, state == ST_RX_STAY,
                               state == ST_SEEK || state == ST_RX_TUNE,
                               state != ST_IDLE};
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (is_table) begin
            rd_mux = hop_table[tbl_addr];
        end else begin
            case (reg_addr_i)
                REG_INTEGER:     rd_mux = integer_divide_value;
                REG_FRAC_HIGH:   rd_mux = fraction_divide_value[23:16];
                REG_FRAC_MID:    rd_mux = fraction_divide_value[15:8];
                REG_FRAC_LOW:    rd_mux = fraction_divide_value[7:0];
                REG_STEP_HIGH:   rd_mux = step_size[15:8];
                REG_STEP_LOW:    rd_mux = step_size[7:0];
                REG_OUTDIV:      rd_mux = outdiv;
                REG_HOP_CTRL:    rd_mux = hop_ctrl;
                REG_TABLE_SIZE:  rd_mux = {1'b0, table_size};
                REG_RSSI_THRESH: rd_mux = signal_level_threshold;
                REG_PRE_TIMEOUT: rd_mux = preamble_timeout_setting;
                REG_SYNC_TMO:    rd_mux = sync_timeout_setting;
                REG_CAL_COUNT:   rd_mux = oscillator_cal_count[7:0];
                REG_STATUS:      rd_mux = status;
                REG_CHANNEL:     rd_mux = channel;
                REG_FREQ_B0:     rd_mux = rf_hz_q19[26:19];
                default:         rd_mux = 8'h00;
            endcase
        end
    end

    // Registered read data and synthesizer word
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            reg_rdata_o  <= 8'h00;
            synth_word_o <= 48'h000000000000;
        end else begin
            reg_rdata_o  <= reg_rd_i ? rd_mux : 8'h00;
            synth_word_o <= rf_hz_q19[47:0];
        end
    end

    assign outdiv_o    = outdiv;
    assign cal_count_o = oscillator_cal_count;
    assign channel_o   = channel;
    assign tuning_o    = (state == ST_RX_TUNE) || (state == ST_SEEK);
    assign receiving_o = (state == ST_RX_LISTEN) || (state == ST_RX_STAY);
    assign hop_gpio_o  = gpio_q;
endmodule

// ==== testbench/sch_hop_control_asserts.sv ====
// Port checker for the channel hop controller
module sch_hop_checker
    import sch_pkg::*;
#(
    parameter int AUTO_HOP_CYCLES   = 20,
    parameter int MANUAL_HOP_CYCLES = 10
) (
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       cmd_start_rx_i,
    input wire logic       cmd_start_tx_i,
    input wire logic       cmd_has_chan_i,
    input wire logic [7:0] cmd_chan_i,
    input wire logic       cmd_rx_hop_i,
    input wire logic       cmd_idle_i,
    input wire logic [7:0] outdiv_o,
    input wire logic [7:0] channel_o,
    input wire logic       tuning_o,
    input wire logic       receiving_o,
    input wire logic       hop_gpio_o,
    input wire logic       div_error_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // Decoded command and divider write events
    // ----------------
    wire logic go_rx   = cmd_start_rx_i && !cmd_idle_i;
    wire logic go_any  = (cmd_start_rx_i || cmd_start_tx_i) && !cmd_idle_i;
    wire logic hop_rq  = cmd_rx_hop_i && receiving_o && !go_any && !cmd_idle_i;
    wire logic div_wr  = reg_wr_i && reg_addr_i == REG_OUTDIV;
    wire logic div_std = reg_wdata_i inside {8'd24, 8'd12, 8'd8, 8'd4};
    wire logic div_ext = div_std || reg_wdata_i inside {8'd16, 8'd6};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Tuning spans the full turnaround before listening
    property p_start_rx;
        go_rx |=> tuning_o ##(AUTO_HOP_CYCLES - 1) tuning_o ##1 receiving_o;
    endproperty
    a_start_rx: assert property (p_start_rx)
        else $error("receive start timing wrong");
    property p_manual;
        hop_rq |=> tuning_o ##(MANUAL_HOP_CYCLES - 1) tuning_o ##1 receiving_o;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual hop timing wrong");
    property p_manual_chan;
        hop_rq && cmd_has_chan_i |=> channel_o == $past(cmd_chan_i);
    endproperty
    a_manual_chan: assert property (p_manual_chan)
        else $error("manual hop channel not taken");
    property p_chan_set;
        go_any && cmd_has_chan_i |=> channel_o == $past(cmd_chan_i);
    endproperty
    a_chan_set: assert property (p_chan_set)
        else $error("start channel not taken");
    property p_chan_keep;
        go_any && !cmd_has_chan_i |=> $stable(channel_o);
    endproperty
    a_chan_keep: assert property (p_chan_keep)
        else $error("channel lost on start without argument");
    property p_reset;
        disable iff (1'b0)
        !nrst_i |=> channel_o == CHANNEL_RESET && !hop_gpio_o && !receiving_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");
    property p_gpio;
        $changed(hop_gpio_o) |-> tuning_o;
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("hop output toggled outside a hop");
    property p_div_ok;
        div_wr && div_std |=> outdiv_o == $past(reg_wdata_i) && !div_error_o;
    endproperty
    a_div_ok: assert property (p_div_ok)
        else $error("legal divider refused");
    property p_div_bad;
        div_wr && !div_ext |=> div_error_o && $stable(outdiv_o);
    endproperty
    a_div_bad: assert property (p_div_bad)
        else $error("illegal divider accepted");

    // Main scenarios reached
    c_manual: cover property (hop_rq);
    c_gpio:   cover property ($changed(hop_gpio_o));
    c_div:    cover property (div_wr && !div_std);
endmodule

// ==== testbench/sch_host_model.sv ====
// Host model issuing radio commands to the hop controller
module sch_host_model (
    input  wire logic       clk_sys_i,
    output logic            cmd_start_rx_o,
    output logic            cmd_start_tx_o,
    output logic            cmd_rx_hop_o,
    output logic            cmd_idle_o,
    output logic            cmd_has_chan_o,
    output logic      [7:0] cmd_chan_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quiet command lines from time zero
    initial begin
        {cmd_start_rx_o, cmd_start_tx_o, cmd_rx_hop_o, cmd_idle_o} = 4'h0;
        cmd_has_chan_o = 1'b0;
        cmd_chan_o     = 8'h5a;
    end
    // One-cycle command: 0 start rx, 1 start tx, 2 manual hop, 3 idle
    task automatic cmd(input int kind, input logic has, input logic [7:0] ch);
        @(posedge clk_sys_i);
        cmd_start_rx_o <= kind == 0;
        cmd_start_tx_o <= kind == 1;
        cmd_rx_hop_o   <= kind == 2;
        cmd_idle_o     <= kind == 3;
        cmd_has_chan_o <= has;
        cmd_chan_o     <= has ? ch : ~ch; // Noise when unqualified
        @(posedge clk_sys_i);
        {cmd_start_rx_o, cmd_start_tx_o, cmd_rx_hop_o, cmd_idle_o} <= 4'h0;
        cmd_has_chan_o <= 1'b0;
        cmd_chan_o     <= ~cmd_chan_o; // Released lines carry no channel
    endtask
endmodule

// ==== testbench/sch_hop_control_bench.sv ====
// Self-checking bench of the channel hop controller
module sch_hop_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import sch_pkg::*;
    // ----------------
    // Shortened timing, expected words and signals
    // ----------------
    localparam int AH = 20;
    localparam int MH = 10;
    localparam int TU = 4;
    localparam logic [47:0] BASE = (48'h40 << 19) + 48'h0a0034;
    localparam logic [47:0] STEP = 48'h0102;
    logic        clk_sys_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0, preamble_ok_i = 1'b0, sync_ok_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rssi_i = 8'h00;
    logic [15:0] tx_mod_i = 16'h0010;
    logic        cmd_start_rx_i, cmd_start_tx_i, cmd_has_chan_i, cmd_rx_hop_i;
    logic        cmd_idle_i, tuning_o, receiving_o, hop_gpio_o, div_error_o;
    logic [7:0]  cmd_chan_i, reg_rdata_o, outdiv_o, channel_o, d, e;
    logic [15:0] cal_count_o;
    logic [47:0] synth_word_o, w;
    int          fails = 0, cmp_count = 0, n;
    logic [7:0]  dv [8] = '{8'd24, 8'd16, 8'd12, 8'd6, 8'd8, 8'd4, 8'd16, 8'd6};
    logic [7:0]  tb [4] = '{8'h05, UNUSED_ENTRY, 8'h07, 8'h09};

    initial forever #2.5 clk_sys_i = ~clk_sys_i;

    sch_hop_control #(
        .AUTO_HOP_CYCLES(AH), .MANUAL_HOP_CYCLES(MH), .TMO_UNIT_CYCLES(TU)
    ) DUT (
        .clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .cmd_start_rx_i, .cmd_start_tx_i, .cmd_has_chan_i,
        .cmd_chan_i, .cmd_rx_hop_i, .cmd_idle_i, .rssi_i, .preamble_ok_i,
        .sync_ok_i, .tx_mod_i, .synth_word_o, .outdiv_o, .cal_count_o,
        .channel_o, .tuning_o, .receiving_o, .hop_gpio_o, .div_error_o
    );
    sch_host_model u_host (
        .clk_sys_i, .cmd_start_rx_o(cmd_start_rx_i),
        .cmd_start_tx_o(cmd_start_tx_i), .cmd_rx_hop_o(cmd_rx_hop_i),
        .cmd_idle_o(cmd_idle_i), .cmd_has_chan_o(cmd_has_chan_i),
        .cmd_chan_o(cmd_chan_i)
    );
    // Compare and count
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Register access: one strobe cycle, read data in the next
    task automatic acc(input logic wr, input logic [7:0] a, wd);
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {wr, !wr, a, wd};
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i} <= 2'b00;
        @(negedge clk_sys_i);
        d = reg_rdata_o;
    endtask
    // Count cycles until the receive level is seen, bounded
    task automatic wait_rcv(input logic lvl, input int lim, output int k);
        k = 0;
        do begin
            @(negedge clk_sys_i);
            k++;
        end while (receiving_o !== lvl && k < lim);
    endtask
    task automatic finish_test;
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        acc(1'b0, REG_INTEGER, 8'h00);
        chk(48'(d), 48'(INTEGER_RESET));
        chk(48'(channel_o), 48'(CHANNEL_RESET));
        acc(1'b0, 8'h0f, 8'h00);
        chk(48'(d), 48'h0);
        e = OUTDIV_RESET;
        for (int i = 0; i < 8; i++) begin
            if (i == 6) acc(1'b1, REG_HOP_CTRL, 8'h01 << HC_EXTB_BIT);
            acc(1'b1, REG_OUTDIV, dv[i]);
            if (i >= 6 || dv[i] inside {8'd24, 8'd12, 8'd8, 8'd4}) e = dv[i];
            chk(48'(outdiv_o), 48'(e));
            chk(48'(div_error_o), 48'(e !== dv[i]));
        end
        acc(1'b1, REG_INTEGER, 8'h40);
        acc(1'b1, REG_FRAC_HIGH, 8'h0a);
        acc(1'b1, REG_FRAC_LOW, 8'h34);
        acc(1'b1, REG_STEP_HIGH, 8'h01);
        acc(1'b1, REG_STEP_LOW, 8'h02);
        // Base, channel five, then transmit keeping channel five
        for (int i = 0; i < 3; i++) begin
            u_host.cmd(i / 2, i == 1, 8'h05);
            repeat (AH + 4) @(negedge clk_sys_i);
            e = (i > 0) ? 8'd5 : 8'd0;
            w = BASE + e * STEP + ((i == 2) ? 48'h10 : 48'h0);
            w = 48'(64'(w) * 64'd60000000 / 64'(dv[7])); // Twice 30 MHz
            chk(synth_word_o, w);
            chk(48'(channel_o), 48'(e));
            chk(48'(receiving_o), 48'(i < 2));
        end
        u_host.cmd(0, 1'b0, 8'h00);
        wait_rcv(1'b1, 300, n);
        acc(1'b1, REG_CAL_COUNT, 8'h12);
        acc(1'b1, REG_CAL_COUNT, 8'h34);
        chk(48'(cal_count_o), 48'h1234);
        u_host.cmd(2, 1'b1, 8'h21);
        wait_rcv(1'b0, 300, n);
        wait_rcv(1'b1, 300, n);
        chk(48'(channel_o), 48'h21);
        chk(48'(n <= MH + 1), 48'h1);
        // Hop table with one unused entry
        u_host.cmd(3, 1'b0, 8'h00);
        acc(1'b1, REG_TABLE_SIZE, 8'd4);
        for (int i = 0; i < 4; i++)
            acc(1'b1, REG_TABLE_BASE + 8'(i), tb[i]);
        acc(1'b1, REG_RSSI_THRESH, 8'h40);
        acc(1'b1, REG_HOP_CTRL, 8'h23);
        @(posedge clk_sys_i);
        rssi_i <= 8'h41;
        u_host.cmd(0, 1'b1, tb[0]);
        repeat (AH + 60) @(negedge clk_sys_i);
        chk(48'(channel_o), 48'h05);
        chk(48'(hop_gpio_o), 48'h0);
        @(posedge clk_sys_i);
        rssi_i <= 8'h40;
        // Entry one skipped; wrap toggles the output a second time
        for (int i = 0; i < 3; i++) begin
            wait_rcv(1'b0, 300, n);
            wait_rcv(1'b1, 300, n);
            chk(48'(channel_o), 48'(tb[(i + 2) % 4]));
            chk(48'(hop_gpio_o), 48'(i == 0));
            chk(48'(n <= AH + 3), 48'h1);
        end
        // Preamble timeout, first in raw mode, then with packet handling
        acc(1'b1, REG_PRE_TIMEOUT, 8'd2);
        for (int i = 0; i < 2; i++) begin
            u_host.cmd(3, 1'b0, 8'h00);
            acc(1'b1, REG_HOP_CTRL, (i == 1) ? 8'h05 : 8'h15);
            u_host.cmd(0, 1'b1, tb[0]);
            wait_rcv(1'b1, 300, n);
            wait_rcv(1'b0, 60, n);
            chk(48'(receiving_o), 48'(i == 0));
        end
        chk(48'(n >= 2 * TU - 1 && n <= 2 * TU + 3), 48'h1);
        wait_rcv(1'b1, 300, n);
        chk(48'(channel_o), 48'h07);
        wait_rcv(1'b0, 60, n);
        chk(48'(n >= 2 * TU - 1 && n <= 2 * TU + 3), 48'h1);
        u_host.cmd(3, 1'b0, 8'h00);
        @(negedge clk_sys_i);
        chk(48'(receiving_o | tuning_o), 48'h0);
        finish_test();
    end
    // Watchdog against a hang
    initial begin
        #250000;
        fails++;
        finish_test();
    end
endmodule

bind sch_hop_control sch_hop_checker #(
    .AUTO_HOP_CYCLES(AUTO_HOP_CYCLES), .MANUAL_HOP_CYCLES(MANUAL_HOP_CYCLES)
) u_chk (
    .clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .cmd_start_rx_i, .cmd_start_tx_i, .cmd_has_chan_i, .cmd_chan_i,
    .cmd_rx_hop_i, .cmd_idle_i, .outdiv_o, .channel_o, .tuning_o,
    .receiving_o, .hop_gpio_o, .div_error_o
);
